// ===== design/btl_exec.sv
// Design decisions made here: the register addresses and the AHB-Lite slave port.
module btl_exec
    import btl_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);

    btl_state_t s;
    btl_state_t next_s;

    logic [7:0] lct_mem [256];
    logic [7:0] ext_mem [65536];

    // Combinational memory ports and decode terms
    logic        tbl_we;
    logic [7:0]  tbl_wa;
    logic [7:0]  tbl_wd;
    logic        ext_we;
    logic [15:0] ext_wa;
    logic [7:0]  ext_wd;
    logic        issue;
    logic        legal;
    logic        is_ext;
    logic [7:0]  src;
    logic [7:0]  mask;
    logic [7:0]  entry_opa;
    logic [7:0]  entry_idx;
    logic [15:0] ext_ea;
    logic        commit;
    logic [7:0]  wdat;

    assign hreadyout = 1'b1; // Zero wait states
    assign hresp     = 1'b0;
    assign hrdata    = s.rdata;

    // Operand fetch from the current instruction bytes and the index register
    assign entry_opa = lct_mem[s.opa];
    assign entry_idx = lct_mem[s.index];
    assign ext_ea    = {entry_opa, s.index};
    assign commit    = s.busy && (s.count == 10'h001);
    assign wdat      = hwdata[7:0];

    always_comb begin
        next_s = s;
        tbl_we = 1'b0;
        tbl_wa = s.wb_addr[7:0];
        tbl_wd = s.wb_val;
        ext_we = 1'b0;
        ext_wa = s.wb_addr;
        ext_wd = s.wb_val;
        issue  = 1'b0;
        legal  = 1'b1;
        is_ext = 1'b0;
        src    = RST_BYTE;
        mask   = s.opa;

        // Instruction decode; the bytes were latched on the issue write
        case (s.op)
            OP_BT_WORK:    src = s.work;
            OP_BT_INDEX:   src = s.index;
            OP_BT_EXT, OP_TC_EXT, OP_TS_EXT: begin
                is_ext = 1'b1;
                src    = ext_mem[ext_ea];
                mask   = s.opb;
            end
            OP_TC_ENTRY, OP_TS_ENTRY: begin
                src  = entry_opa;
                mask = s.opb;
            end
            OP_TC_INDEXED, OP_TS_INDEXED: src = entry_idx;
            OP_LD_MAIN:    src = s.data_byte;
            OP_LD_ENTRY:   src = entry_opa;
            default:       legal = 1'b0;
        endcase
        if (is_ext && !s.ext_en) begin
            legal = 1'b0;
        end

        // Bus data phase; refused while busy except control and the status illegal-flag clear
        next_s.wr_pend = 1'b0;
        if (s.wr_pend) begin
            case (s.wr_addr)
                ADDR_CTRL: next_s.ext_en = hwdata[CTRL_EXT_EN_BIT];
                ADDR_STATUS: begin
                    if (!s.busy) begin
                        next_s.sign      = hwdata[ST_SIGN_BIT];
                        next_s.zero      = hwdata[ST_ZERO_BIT];
                        next_s.carry     = hwdata[ST_CARRY_BIT];
                        next_s.last_char = hwdata[ST_LAST_BIT];
                    end
                    if (hwdata[ST_ILLEGAL_BIT]) begin
                        next_s.illegal = 1'b0;
                    end
                end
                default: begin
                    if (!s.busy) begin
                        case (s.wr_addr)
                            ADDR_INSTR: begin
                                issue      = 1'b1;
                                next_s.op  = hwdata[7:0];
                                next_s.opa = hwdata[15:8];
                                next_s.opb = hwdata[23:16];
                            end
                            ADDR_WORK:     next_s.work      = wdat;
                            ADDR_INDEX:    next_s.index     = wdat;
                            ADDR_RANGE:    next_s.range     = hwdata[15:0];
                            ADDR_DATABYTE: next_s.data_byte = wdat;
                            ADDR_TBL_ADDR: next_s.tbl_addr  = wdat;
                            ADDR_EXT_ADDR: next_s.ext_addr  = hwdata[15:0];
                            ADDR_TBL_DATA: begin
                                tbl_we = 1'b1;
                                tbl_wa = s.tbl_addr;
                                tbl_wd = wdat;
                            end
                            ADDR_EXT_DATA: begin
                                ext_we = 1'b1;
                                ext_wa = s.ext_addr;
                                ext_wd = wdat;
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end

        // Execute phase: the operation resolves one cycle after issue
        if (s.busy && s.count == 10'h000) begin
            next_s.count = CYC_SHORT;
        end
        if (s.busy) begin
            next_s.count = s.count - 10'h001;
        end
        if (commit) begin
            next_s.busy = 1'b0;
            next_s.sign = s.result[7];
            next_s.zero = (s.result == RST_BYTE);
            if (s.lc_upd) begin
                next_s.last_char = s.lc_val;
            end
            if (s.ld_work) begin
                next_s.work = s.result;
            end
            // Carry is never touched here
            if (s.wb_kind == WB_TBL) begin
                tbl_we = 1'b1;
            end
            if (s.wb_kind == WB_EXT) begin
                ext_we = 1'b1;
            end
        end

        // Issue: latch the opcode and set busy; operands resolve next cycle, commit at the end
        if (issue) begin
            next_s.busy    = 1'b1;
            next_s.count   = 10'h000;
            next_s.wb_kind = WB_NONE;
            next_s.ld_work = 1'b0;
            next_s.lc_upd  = 1'b0;
        end

        next_s.rdata = {
            24'h000000, RST_BYTE};
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                ADDR_CTRL:   next_s.rdata[CTRL_EXT_EN_BIT] = s.ext_en;
                ADDR_INSTR:  next_s.rdata[23:0] = {s.opb, s.opa, s.op};
                ADDR_STATUS: next_s.rdata[5:0] = {s.illegal, s.last_char,
                    s.carry, s.zero, s.sign, s.busy};
                ADDR_WORK:     next_s.rdata[7:0]  = s.work;
                ADDR_INDEX:    next_s.rdata[7:0]  = s.index;
                ADDR_RANGE:    next_s.rdata[15:0] = s.range;
                ADDR_DATABYTE: next_s.rdata[7:0]  = s.data_byte;
                ADDR_TBL_ADDR: next_s.rdata[7:0]  = s.tbl_addr;
                ADDR_TBL_DATA: next_s.rdata[7:0]  = lct_mem[s.tbl_addr];
                ADDR_EXT_ADDR: next_s.rdata[15:0] = s.ext_addr;
                ADDR_EXT_DATA: next_s.rdata[7:0]  = ext_mem[s.ext_addr];
                ADDR_RESULT:   next_s.rdata[7:0]  = s.result;
                default: ; // Unmapped reads as zero
            endcase
        end
        if (hsel && hready && htrans[1] && hwrite) begin
            next_s.wr_pend = 1'b1;
            next_s.wr_addr = haddr[7:0];
        end
    end

    // Second stage of issue: resolve operands of the latched opcode.
    // Kept apart so operands are read after the issue bytes settle.
    btl_state_t exec_s;
    always_comb begin
        exec_s = next_s;
        if (s.busy && s.count == 10'h000) begin
            if (!legal) begin
                exec_s.busy    = 1'b0;
                exec_s.illegal = 1'b1;
                exec_s.count   = 10'h000;
            end else begin
                exec_s.result  = src & mask;
                exec_s.wb_addr = is_ext ? ext_ea : {RST_BYTE, s.opa};
                exec_s.count   = CYC_SHORT - 10'h001;
                case (s.op)
                    OP_TC_ENTRY, OP_TC_INDEXED, OP_TC_EXT: begin
                        exec_s.wb_val = src & ~mask;
                    end
                    OP_TS_ENTRY, OP_TS_INDEXED, OP_TS_EXT: begin
                        exec_s.wb_val = src | mask;
                    end
                    default: exec_s.wb_val = src;
                endcase
                case (s.op)
                    OP_TC_INDEXED, OP_TS_INDEXED: begin
                        exec_s.wb_addr = {RST_BYTE, s.index};
                    end
                    default: ;
                endcase
                case (s.op)
                    OP_BT_EXT: exec_s.count = CYC_EXTBT - 10'h002;
                    OP_TC_EXT, OP_TS_EXT: begin
                        exec_s.count   = CYC_EXTMOD - 10'h002;
                        exec_s.wb_kind = WB_EXT;
                    end
                    OP_TC_ENTRY, OP_TC_INDEXED, OP_TS_ENTRY,
                    OP_TS_INDEXED: begin
                        exec_s.count   = CYC_ENTRY - 10'h002;
                        exec_s.wb_kind = WB_TBL;
                    end
                    OP_LD_MAIN: begin
                        exec_s.result  = s.data_byte;
                        exec_s.ld_work = 1'b1;
                        exec_s.lc_upd  = 1'b1;
                        exec_s.lc_val  = (s.range - 16'h0001) == RST_HALF;
                        exec_s.count   = CYC_SHORT - 10'h002;
                    end
                    OP_LD_ENTRY: begin
                        exec_s.result  = entry_opa;
                        exec_s.ld_work = 1'b1;
                        exec_s.count   = CYC_SHORT - 10'h002;
                    end
                    default: exec_s.count = CYC_SHORT - 10'h002;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= exec_s;
        end
    end

    // Memories have no reset; contents are loaded by software
    always_ff @(posedge hclk) begin
        if (tbl_we) begin
            lct_mem[tbl_wa] <= tbl_wd;
        end
        if (ext_we) begin
            ext_mem[ext_wa] <= ext_wd;
        end
    end

    // Instruction length from issue write to flag update
    logic       issue_d;
    logic [7:0] issue_op;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            issue_d  <= 1'b0;
            issue_op <= RST_BYTE;
        end else begin
            issue_d  <= issue;
            issue_op <= next_s.op;
        end
    end

    short_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        issue_d && issue_op == OP_BT_WORK |-> ##73 s.busy ##1 !s.busy)
        else $error("working register test length wrong");

    sign_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
        commit |=> s.sign == $past(s.result[7]))
        else $error("sign flag does not follow result msb");

    zero_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        commit |=> s.zero == ($past(s.result) == 8'h00))
        else $error("zero flag does not follow result");

    carry_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
        commit |=> $stable(s.carry))
        else $error("carry changed by instruction");

    ext_illegal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && is_ext && !s.ext_en
        |=> s.illegal && !s.busy && $stable(s.sign))
        else $error("extended form ran while disabled");

    index_test_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && s.op == OP_BT_INDEX
        |=> s.result == ($past(s.index) & $past(s.opa)))
        else $error("index bit test result wrong");

    ext_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && is_ext && s.ext_en
        |=> s.wb_addr == {$past(entry_opa), $past(s.index)})
        else $error("extended address formed wrongly");

    ext_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && s.op == OP_BT_EXT && s.ext_en
        |=> s.count == CYC_EXTBT - 10'h002)
        else $error("extended test length wrong");

    clear_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && s.op == OP_TC_INDEXED
        |=> s.wb_val == ($past(entry_idx) & ~$past(s.opa))
            && s.wb_addr[7:0] == $past(s.index))
        else $error("indexed clear value wrong");

    set_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && s.op == OP_TS_ENTRY
        |=> s.wb_val == ($past(entry_opa) | $past(s.opb)))
        else $error("entry set value wrong");

    last_char_a: assert property (@(posedge hclk) disable iff (!hresetn)
        commit && s.lc_upd
        |=> s.last_char == ($past(s.range) == 16'h0001))
        else $error("last char flag wrong");

    load_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s.busy && s.count == 10'h000 && s.op == OP_LD_ENTRY
        |=> s.result == $past(entry_opa) && s.ld_work)
        else $error("entry load value wrong");

endmodule // btl_exec

// ===== common/btl_pkg.sv
package btl_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_INSTR    = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_WORK     = 8'h0C;
    localparam logic [7:0] ADDR_INDEX    = 8'h10;
    localparam logic [7:0] ADDR_RANGE    = 8'h14;
    localparam logic [7:0] ADDR_DATABYTE = 8'h18;
    localparam logic [7:0] ADDR_TBL_ADDR = 8'h1C;
    localparam logic [7:0] ADDR_TBL_DATA = 8'h20;
    localparam logic [7:0] ADDR_EXT_ADDR = 8'h24;
    localparam logic [7:0] ADDR_EXT_DATA = 8'h28;
    localparam logic [7:0] ADDR_RESULT   = 8'h2C;

    // Field positions
    localparam int CTRL_EXT_EN_BIT = 4;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_SIGN_BIT     = 1;
    localparam int ST_ZERO_BIT     = 2;
    localparam int ST_CARRY_BIT    = 3;
    localparam int ST_LAST_BIT     = 4;
    localparam int ST_ILLEGAL_BIT  = 5;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;

    // Opcode bytes, first nibble high
    localparam logic [7:0] OP_BT_WORK    = 8'h97;
    localparam logic [7:0] OP_BT_INDEX   = 8'hB7;
    localparam logic [7:0] OP_BT_EXT     = 8'hC7;
    localparam logic [7:0] OP_TC_ENTRY   = 8'h7A;
    localparam logic [7:0] OP_TC_INDEXED = 8'h8A;
    localparam logic [7:0] OP_TC_EXT     = 8'hCA;
    localparam logic [7:0] OP_TS_ENTRY   = 8'h76;
    localparam logic [7:0] OP_TS_INDEXED = 8'h86;
    localparam logic [7:0] OP_TS_EXT     = 8'hC6;
    localparam logic [7:0] OP_LD_MAIN    = 8'h10;
    localparam logic [7:0] OP_LD_ENTRY   = 8'h50;

    // Execution times in ns and their cycle counts
    localparam int CLK_MHZ     = 100;
    localparam int T_SHORT_NS  = 750;
    localparam int T_ENTRY_NS  = 2300;
    localparam int T_EXTBT_NS  = 6100;
    localparam int T_EXTMOD_NS = 7900;
    localparam logic [9:0] CYC_SHORT  = 10'(T_SHORT_NS * CLK_MHZ / 1000);
    localparam logic [9:0] CYC_ENTRY  = 10'(T_ENTRY_NS * CLK_MHZ / 1000);
    localparam logic [9:0] CYC_EXTBT  = 10'(T_EXTBT_NS * CLK_MHZ / 1000);
    localparam logic [9:0] CYC_EXTMOD = 10'(T_EXTMOD_NS * CLK_MHZ / 1000);

    typedef enum logic [1:0] {WB_NONE, WB_TBL, WB_EXT} btl_wb_t;

    typedef struct packed {
        logic        ext_en;
        logic        busy;
        logic [9:0]  count;
        logic [7:0]  op;
        logic [7:0]  opa;
        logic [7:0]  opb;
        logic        sign;
        logic        zero;
        logic        carry;
        logic        last_char;
        logic        illegal;
        logic [7:0]  work;
        logic [7:0]  index;
        logic [7:0]  result;
        logic [7:0]  data_byte;
        logic [15:0] range;
        logic [7:0]  tbl_addr;
        logic [15:0] ext_addr;
        btl_wb_t     wb_kind;
        logic [15:0] wb_addr;
        logic [7:0]  wb_val;
        logic        ld_work;
        logic        lc_upd;
        logic        lc_val;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } btl_state_t;

endpackage

// ===== sim/btl_host.sv
// Bus master standing in for the channel program fetch stream
module btl_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned cyc;
    int unsigned addr_cyc;
    logic        rdy_q;
    logic [31:0] rd_q;

    initial begin
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Values as they stand just before each rising edge, free of races
    always @(negedge hclk) begin
        rdy_q <= hready;
        rd_q  <= hrdata;
    end

    // Free-running cycle count for timing checks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cyc <= 0;
        else cyc <= cyc + 1;
    end

    // One single word transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (rdy_q !== 1'b1);
        addr_cyc = cyc;
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        do @(posedge hclk); while (rdy_q !== 1'b1);
        rd = rd_q;
        // Released data must not look like the last value
        hwdata <= ~wd;
    endtask
endmodule // btl_host

// ===== sim/bit_test_load_execute_bench.sv
module bit_test_load_execute_bench
    import btl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [15:0] seed;
    int          err_total;
    int          n_checks;
    int          tbl_m [256];
    int          ext_m [int];
    int          ext_en;
    int          pass;
    logic [7:0]  ops [11] = '{OP_BT_WORK, OP_BT_INDEX, OP_BT_EXT,
        OP_TC_ENTRY, OP_TC_INDEXED, OP_TC_EXT, OP_TS_ENTRY,
        OP_TS_INDEXED, OP_TS_EXT, OP_LD_MAIN, OP_LD_ENTRY};

    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    btl_host u_btl_host (.hclk, .hresetn, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata);

    btl_exec u_btl_exec (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp);

    function automatic int rnd8();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return int'(seed[7:0]);
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input int exp, string what);
        n_checks++;
        if (got !== 32'(exp)) begin
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] r;
        u_btl_host.xfer(1'b1, a, 32'(d), r);
    endtask

    task automatic rdv(input logic [7:0] a, output logic [31:0] d);
        u_btl_host.xfer(1'b0, a, 32'h0, d);
        chk({31'h0, hresp}, 0, "response");
    endtask

    // Loads operands, runs one opcode and compares against the model
    task automatic run_op(input logic [7:0] op);
        int a, b, w, x, rg, f, ea, res, n, t0, el, sg, zr, cy, lc, il;
        logic [31:0] d;
        bit leg;
        a = rnd8();
        b = rnd8();
        w = rnd8();
        x = rnd8();
        rg = (pass == 2) ? rnd8() : pass;
        f = rnd8() & 30;
        wr(ADDR_WORK, w);
        wr(ADDR_INDEX, x);
        wr(ADDR_DATABYTE, b ^ 8'h5A);
        wr(ADDR_RANGE, rg);
        tbl_m[a] = rnd8();
        wr(ADDR_TBL_ADDR, a);
        wr(ADDR_TBL_DATA, tbl_m[a]);
        tbl_m[x] = rnd8();
        wr(ADDR_TBL_ADDR, x);
        wr(ADDR_TBL_DATA, tbl_m[x]);
        ea = tbl_m[a] * 256 + x;
        ext_m[ea] = rnd8();
        wr(ADDR_EXT_ADDR, ea);
        wr(ADDR_EXT_DATA, ext_m[ea]);
        wr(ADDR_STATUS, f | 32);
        sg = (f >> 1) & 1;
        zr = (f >> 2) & 1;
        cy = (f >> 3) & 1;
        lc = (f >> 4) & 1;
        il = 0;
        leg = (op[7:4] != 4'hC) || ext_en != 0;
        res = 0;
        // Reference behaviour of each opcode
        case (op)
            OP_BT_WORK:    res = w & a;
            OP_BT_INDEX:   res = x & a;
            OP_BT_EXT:     res = ext_m[ea] & b;
            OP_TC_ENTRY:   res = tbl_m[a] & b;
            OP_TC_INDEXED: res = tbl_m[x] & a;
            OP_TC_EXT:     res = ext_m[ea] & b;
            OP_TS_ENTRY:   res = tbl_m[a] & b;
            OP_TS_INDEXED: res = tbl_m[x] & a;
            OP_TS_EXT:     res = ext_m[ea] & b;
            OP_LD_MAIN:    res = b ^ 8'h5A;
            default:       res = tbl_m[a];
        endcase
        case (op)
            OP_BT_EXT, OP_TC_EXT, OP_TS_EXT: n = int'(CYC_EXTBT);
            OP_TC_ENTRY, OP_TC_INDEXED: n = int'(CYC_ENTRY);
            OP_TS_ENTRY, OP_TS_INDEXED: n = int'(CYC_ENTRY);
            default: n = int'(CYC_SHORT);
        endcase
        if (op == OP_TC_EXT || op == OP_TS_EXT) n = int'(CYC_EXTMOD);
        if (leg) begin
            sg = (res >> 7) & 1;
            zr = (res == 0);
            if (op == OP_TC_ENTRY) tbl_m[a] &= ~b;
            if (op == OP_TC_INDEXED) tbl_m[x] &= ~a;
            if (op == OP_TC_EXT) ext_m[ea] &= ~b;
            if (op == OP_TS_ENTRY) tbl_m[a] |= b;
            if (op == OP_TS_INDEXED) tbl_m[x] |= a;
            if (op == OP_TS_EXT) ext_m[ea] |= b;
            if (op == OP_LD_MAIN) lc = (rg == 1);
            if (op == OP_LD_MAIN || op == OP_LD_ENTRY) w = res;
        end else begin
            il = 1;
            n = 1;
        end
        wr(ADDR_INSTR, (b << 16) | (a << 8) | op);
        t0 = u_btl_host.cyc;
        // A write while busy must be dropped
        if (leg) wr(ADDR_WORK, w ^ 8'hFF);
        do rdv(ADDR_STATUS, d); while (d[0] === 1'b1);
        el = u_btl_host.addr_cyc - t0;
        chk({31'h0, el >= n && el <= n + 4}, 1, "busy time");
        chk(d & 32'h3F, (il << 5) | (lc << 4) | (cy << 3) | (zr << 2)
            | (sg << 1), "status");
        rdv(ADDR_WORK, d);
        chk(d, w, "work");
        if (leg && op[7:4] != 4'h1 && op[7:4] != 4'h5) begin
            rdv(ADDR_RESULT, d);
            chk(d, res, "result");
        end
        wr(ADDR_TBL_ADDR, a);
        rdv(ADDR_TBL_DATA, d);
        chk(d, tbl_m[a], "entry");
        wr(ADDR_TBL_ADDR, x);
        rdv(ADDR_TBL_DATA, d);
        chk(d, tbl_m[x], "indexed entry");
        wr(ADDR_EXT_ADDR, ea);
        rdv(ADDR_EXT_DATA, d);
        chk(d, ext_m[ea], "extended");
    endtask

    // Hang guard, well above the expected run of about 10000 cycles
    always @(posedge hclk) begin
        if (u_btl_host.cyc > 40000) begin
            err_total++;
            stop_test;
        end
    end

    initial begin
        logic [31:0] d;
        hresetn = 1'b0;
        seed = 16'h6ADD;
        err_total = 0;
        n_checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdv(ADDR_STATUS, d);
        chk(d, 0, "status reset");
        rdv(ADDR_CTRL, d);
        chk(d, 0, "ctrl reset");
        wr(8'h30, 32'h1234);
        rdv(8'h30, d);
        chk(d, 0, "unmapped");
        $display("test reset done");
        // Pass 0 runs extended forms without enable, so they are refused
        for (pass = 0; pass < 3; pass++) begin
            ext_en = (pass != 0);
            wr(ADDR_CTRL, ext_en << 4);
            rdv(ADDR_CTRL, d);
            chk(d, ext_en << 4, "ctrl");
            foreach (ops[k]) run_op(ops[k]);
            $display("test pass %0d done", pass);
        end
        // Opcode outside the group: refused, only the illegal flag moves
        wr(ADDR_STATUS, 32);
        wr(ADDR_INSTR, 32'h000000FF);
        do rdv(ADDR_STATUS, d); while (d[0] === 1'b1);
        chk(d & 32'h3F, 32, "unknown opcode");
        $display("test unknown opcode done");
        // Reset in mid-run must clear flags, enable and working register
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdv(ADDR_STATUS, d);
        chk(d, 0, "status after reset");
        rdv(ADDR_CTRL, d);
        chk(d, 0, "ctrl after reset");
        rdv(ADDR_WORK, d);
        chk(d, 0, "work after reset");
        $display("test reset in run done");
        stop_test;
    end
endmodule // bit_test_load_execute_bench
